/* adcc_top.sv */
// Chosen here: the address map and the AXI4-Lite slave port.
`include "adcc_cfg.svh"

// How it works
// - Conversion starts when start bit is written high then low.
// - Start bit high holds converter in reset and aborts conversion.
// - Busy flag sets on start sequence, clears on completion.
// - Completion pulses the interrupt request to the interrupt controller.
// - Power enable low switches off converter; results keep old value.
// - Alignment bit chooses left or right justified 12-bit result.
// - Result bits carrying no data read zero.
// - Channel codes 0..11 select an input pin; 12..15 select none.
// - Source field picks external, supply ratio, gain-amp ratio or ground.
// - Internal source disconnects external channel path.
// - Unimplemented control bits read zero.
// - Clock field divides system clock by two to the code.
// - Gain amp input is pin at 0, bandgap at 1.
// - Reference is supply, pin, or gain amp output for 1x.
// - Gain codes give gains 1, 1.667, 2.5, 3.333.
// - Conversion takes 4 sample and 12 convert converter clocks.
module adcc_top #(
  parameter int DATA_BITS = 12,
  parameter int DIV_BITS = 3
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_bit_i,
  output logic core_clk_en_o,
  output adcc_pkg::adcc_analog_t analog_o,
  output logic conv_done_irq_o
);
  // Refused at elaboration: result packing and divider width are fixed
  if (DATA_BITS != 12 || DIV_BITS != 3) begin
    $error("adcc_top supports only 12 data bits and a 3-bit divider");
  end

  logic [7:0] ctrl0_q, ctrl1_q, ctrl2_q;
  logic [7:0] resh_q, resl_q;
  logic busy_q;
  logic [DATA_BITS-1:0] shreg_q;
  logic [3:0] step_q;
  logic [6:0] div_q;
  logic done_q;
  adcc_pkg::adcc_state_t state_q;

  // Write channel: address and data may arrive in either order
  logic aw_held_q, w_held_q;
  logic [11:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_q || aw_fire;
  wire w_have = w_held_q || w_fire;
  wire wr_go = aw_have && w_have && !bvalid_q;
  wire [11:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [7:0] wr_byte = w_held_q ? wbyte_q : s_axi_wdata[7:0];
  wire wr_lane = w_held_q ? wlane_q : s_axi_wstrb[0];

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `ADCC_OFF_CTRL0) || (a == `ADCC_OFF_CTRL1) || (a == `ADCC_OFF_CTRL2)
      || (a == `ADCC_OFF_RESH) || (a == `ADCC_OFF_RESL);
  endfunction

  wire wr_c0 = wr_go && wr_lane && (wr_addr == `ADCC_OFF_CTRL0);
  wire wr_c1 = wr_go && wr_lane && (wr_addr == `ADCC_OFF_CTRL1);
  wire wr_c2 = wr_go && wr_lane && (wr_addr == `ADCC_OFF_CTRL2);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ADCC_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      aw_held_q <= aw_have && !wr_go;
      w_held_q <= w_have && !wr_go;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= addr_known(wr_addr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel, one cycle latency
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Busy bit is masked out of the stored word, so it can be merged in
  wire [7:0] ctrl0_rd = ctrl0_q | (8'(busy_q) << `ADCC_B_BUSY);
  wire [7:0] rd_byte =
    (s_axi_araddr == `ADCC_OFF_CTRL0) ? ctrl0_rd :
    (s_axi_araddr == `ADCC_OFF_CTRL1) ? ctrl1_q :
    (s_axi_araddr == `ADCC_OFF_CTRL2) ? ctrl2_q :
    (s_axi_araddr == `ADCC_OFF_RESH) ? resh_q :
    (s_axi_araddr == `ADCC_OFF_RESL) ? resl_q : 8'h00;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ADCC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= addr_known(s_axi_araddr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control registers; unimplemented bits masked at write
  wire start_bit = ctrl0_q[`ADCC_B_START];
  wire pwr_en = ctrl0_q[`ADCC_B_PWR];
  wire start_fall = wr_c0 && start_bit && !wr_byte[`ADCC_B_START];
  // The power bit of the falling write decides, so a start that powers off never runs
  wire start_go = start_fall && wr_byte[`ADCC_B_PWR];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl0_q <= `ADCC_RST;
      ctrl1_q <= `ADCC_RST;
      ctrl2_q <= `ADCC_RST;
    end else begin
      if (wr_c0) begin
        ctrl0_q <= wr_byte & `ADCC_MASK0;
      end
      if (wr_c1) begin
        ctrl1_q <= wr_byte & `ADCC_MASK1;
      end
      if (wr_c2) begin
        ctrl2_q <= wr_byte & `ADCC_MASK2;
      end
    end
  end

  // Divider: converter clock enable every 2**code system clocks
  wire [2:0] div_code = ctrl1_q[`ADCC_F_DIV];
  wire [6:0] div_max = 7'((8'h01 << div_code) - 8'h01);
  wire tick = (div_q == div_max);
  assign core_clk_en_o = tick && pwr_en && !start_bit;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 7'h00;
    end else if (tick || start_bit || !pwr_en) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  // Sequencer: sampling clocks, then one bit per converter clock, MSB first
  wire last_step = (step_q == 4'(`ADCC_CONV_CLKS - 1));
  wire [DATA_BITS-1:0] result_d = {shreg_q[DATA_BITS-2:0], core_bit_i};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= adcc_pkg::ADCC_IDLE;
      busy_q <= 1'b0;
      step_q <= 4'h0;
      shreg_q <= '0;
      done_q <= 1'b0;
      resh_q <= 8'h00;
      resl_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (start_bit || !pwr_en) begin
        state_q <= adcc_pkg::ADCC_IDLE;
        busy_q <= start_go;
        step_q <= 4'h0;
        if (start_go) begin
          state_q <= adcc_pkg::ADCC_SAMPLE;
        end
      end else if (tick) begin
        unique case (state_q)
          adcc_pkg::ADCC_IDLE: begin
          end
          adcc_pkg::ADCC_SAMPLE: begin
            step_q <= step_q + 4'h1;
            if (step_q == 4'(`ADCC_SAMPLE_CLKS - 1)) begin
              step_q <= 4'h0;
              state_q <= adcc_pkg::ADCC_CONVERT;
            end
          end
          adcc_pkg::ADCC_CONVERT: begin
            shreg_q <= result_d;
            step_q <= step_q + 4'h1;
            if (last_step) begin
              state_q <= adcc_pkg::ADCC_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              if (ctrl0_q[`ADCC_B_ALIGN]) begin
                resh_q <= {4'h0, result_d[11:8]};
                resl_q <= result_d[7:0];
              end else begin
                resh_q <= result_d[11:4];
                resl_q <= {result_d[3:0], 4'h0};
              end
            end
          end
        endcase
      end
    end
  end

  assign conv_done_irq_o = done_q;

  // Analog switch settings
  wire [3:0] src = ctrl1_q[`ADCC_F_SRC];
  wire src_ext = (src == `ADCC_SRC_EXT0) || (src == `ADCC_SRC_EXT1) || (src >= `ADCC_SRC_EXT2);
  wire chan_ok = (ctrl0_q[`ADCC_F_CHAN] <= `ADCC_CHAN_LAST);

  assign analog_o.pwr_en = pwr_en;
  assign analog_o.ext_chan = ctrl0_q[`ADCC_F_CHAN];
  assign analog_o.ext_connect = pwr_en && src_ext && chan_ok;
  assign analog_o.int_src = src;
  assign analog_o.sample = (state_q == adcc_pkg::ADCC_SAMPLE);
  assign analog_o.core_rst = start_bit;
  assign analog_o.ref_sel = ctrl2_q[`ADCC_F_REF];
  assign analog_o.gain_amp_en = ctrl2_q[`ADCC_B_AMP_EN];
  assign analog_o.gain_amp_bg = ctrl2_q[`ADCC_B_AMP_BG];
  assign analog_o.gain_code = ctrl2_q[`ADCC_F_GAIN];
endmodule

/* adcc_cfg.svh */
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
// Byte addresses of the register words
`define ADCC_OFF_CTRL0 12'h000
`define ADCC_OFF_CTRL1 12'h004
`define ADCC_OFF_CTRL2 12'h008
`define ADCC_OFF_RESH 12'h00c
`define ADCC_OFF_RESL 12'h010
// Field positions, start/format/channel word
`define ADCC_B_START 7
`define ADCC_B_BUSY 6
`define ADCC_B_PWR 5
`define ADCC_B_ALIGN 4
`define ADCC_F_CHAN 3:0
// Field positions, source/clock and reference/gain words
`define ADCC_F_SRC 7:4
`define ADCC_F_DIV 2:0
`define ADCC_B_AMP_EN 7
`define ADCC_B_AMP_BG 4
`define ADCC_F_REF 3:2
`define ADCC_F_GAIN 1:0
// Source codes that route the external channel
`define ADCC_SRC_EXT0 4'h0
`define ADCC_SRC_EXT1 4'h4
`define ADCC_SRC_EXT2 4'hc
// Writable masks; unimplemented bits read zero
`define ADCC_MASK0 8'hbf
`define ADCC_MASK1 8'hf7
`define ADCC_MASK2 8'h9f
`define ADCC_RST 8'h00
// Conversion length in converter clocks
`define ADCC_SAMPLE_CLKS 4
`define ADCC_CONV_CLKS 12
`define ADCC_CHAN_LAST 4'hb
`define ADCC_RESP_OKAY 2'b00
`define ADCC_RESP_SLVERR 2'b10
`endif

/* adcc_pkg.sv */
package adcc_pkg;
  typedef struct packed {
    logic pwr_en;
    logic [3:0] ext_chan;
    logic ext_connect;
    logic [3:0] int_src;
    logic sample;
    logic core_rst;
    logic [1:0] ref_sel;
    logic gain_amp_en;
    logic gain_amp_bg;
    logic [1:0] gain_code;
  } adcc_analog_t;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_t;
endpackage

/* adcc_core_model.sv */
module adcc_core_model (
  input wire logic sys_clk_i,
  input wire logic clk_en_i,
  input wire adcc_pkg::adcc_analog_t analog_i,
  input wire logic [11:0] code_i,
  output logic bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idx_q = '0;
  // Past the last bit it drives junk, never a lucky repeat
  assign bit_o = idx_q < 4'hc ? code_i[4'hb - idx_q] : ~code_i[0];
  always @(posedge sys_clk_i) begin
    if (analog_i.core_rst || analog_i.sample) idx_q <= '0;
    else if (clk_en_i) idx_q <= idx_q + 4'h1;
  end
endmodule

/* adcc_chk_sva.sv */
module adcc_chk (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic core_clk_en_o,
  input wire adcc_pkg::adcc_analog_t analog_o,
  input wire logic conv_done_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Convert ticks since sampling; idle ticks may wrap it harmlessly
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= '0;
    else if (analog_o.sample) cnt_q <= '0;
    else if (core_clk_en_o) cnt_q <= cnt_q + 5'h1;
  end
  property p_rst; analog_o.core_rst |-> !core_clk_en_o; endproperty
  a_rst: assert property (p_rst) else $error("tick in reset");
  property p_off; !analog_o.pwr_en |-> !core_clk_en_o; endproperty
  a_off: assert property (p_off) else $error("tick when off");
  property p_pulse; conv_done_irq_o |=> !conv_done_irq_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long irq");
  property p_done; conv_done_irq_o |-> !analog_o.sample && !analog_o.core_rst; endproperty
  a_done: assert property (p_done) else $error("irq mid run");
  property p_iso; analog_o.ext_connect |-> analog_o.int_src[1:0] == 2'h0 || &analog_o.int_src[3:2]; endproperty
  a_iso: assert property (p_iso) else $error("pin path on");
  property p_len; conv_done_irq_o |-> cnt_q == 5'h0c; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_trig; $rose(analog_o.sample) |-> $past(analog_o.core_rst); endproperty
  a_trig: assert property (p_trig) else $error("start without trigger");
  property p_halt; !analog_o.pwr_en |=> !analog_o.sample && !conv_done_irq_o; endproperty
  a_halt: assert property (p_halt) else $error("run while off");
endmodule
bind adcc_top adcc_chk adcc_chk_inst (.sys_clk_i, .rst_n_i, .core_clk_en_o, .analog_o, .conv_done_irq_o);

/* adc_control_registers_tb_top.sv */
`include "adcc_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("unexpected %0t got %h", $time, g); end end
module adc_control_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = '0, rst_n_i = '0, core_bit_i;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0, code = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_clk_en_o, conv_done_irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] v, w0, hi, lo;
  logic [2:0] d;
  logic [33:0] exp_q[$], exp_v;
  adcc_pkg::adcc_analog_t analog_o;
  int errors = 0, checks_done = 0, cyc = 0, t0;
  adcc_top adcc_top_inst (.sys_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_bit_i,
    .core_clk_en_o, .analog_o, .conv_done_irq_o);
  adcc_core_model adcc_core_model_inst (.sys_clk_i, .clk_en_i(core_clk_en_o), .analog_i(analog_o),
    .code_i(code), .bit_o(core_bit_i));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic results();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  always @(posedge sys_clk_i) begin
    if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
      if (exp_q.size() == 0) exp_q.push_back('x);
      exp_v = exp_q.pop_front();
      `CHK(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, exp_v)
    end
  end
  // Leading edge keeps a release and the next raise in separate steps
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] dat, input logic [33:0] e);
    @(posedge sys_clk_i);
    exp_q.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!(s_axi_bvalid || s_axi_rvalid));
    s_axi_bready <= '0;
    s_axi_rready <= '0;
  endtask
  initial begin
    void'($urandom(15));
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= '1;
    for (int a = 0; a < 5; a++) xfer('0, 12'(4 * a), '0, '0);
    xfer('0, 12'h014, '0, {`ADCC_RESP_SLVERR, 32'h0});
    xfer('1, 12'h014, '0, {`ADCC_RESP_SLVERR, 32'h0});
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      v[7:6] = 2'(k);
      xfer('1, 12'h004, v, '0);
      xfer('1, 12'h008, v, '0);
      xfer('1, 12'h000, {4'h2, v[3:0]}, '0);
      `CHK(analog_o.pwr_en, 1'b1)
      `CHK(analog_o.ext_chan, v[3:0])
      `CHK(analog_o.ext_connect, (v[7:4] == 4'h0 || v[7:4] == 4'h4 || v[7:4] >= 4'hc) && v[3:0] <= 4'hb)
      `CHK(analog_o.int_src, v[7:4])
      `CHK(analog_o.ref_sel, v[3:2])
      `CHK(analog_o.gain_amp_en, v[7])
      `CHK(analog_o.gain_amp_bg, v[4])
      `CHK(analog_o.gain_code, v[1:0])
      xfer('0, 12'h000, '0, {26'h0, 4'h2, v[3:0]});
      xfer('0, 12'h004, '0, {26'h0, v & 8'hf7});
      xfer('0, 12'h008, '0, {26'h0, v & 8'h9f});
    end
    for (int i = 0; i < 6; i++) begin
      // Last run uses the slowest divider, the only code near the period window at this clock
      d = (i == 5) ? 3'h7 : 3'(i / 2);
      code = 12'($urandom);
      w0 = {3'h1, i[0], 4'($urandom_range(11))};
      hi = i[0] ? {4'h0, code[11:8]} : code[11:4];
      lo = i[0] ? code[7:0] : {code[3:0], 4'h0};
      xfer('1, 12'h004, {5'h0, d}, '0);
      xfer('1, 12'h000, w0 | 8'h80, '0);
      xfer('1, 12'h000, w0, '0);
      `CHK(analog_o.ext_connect, 1'b1)
      t0 = cyc;
      xfer('0, 12'h000, '0, {26'h0, w0 | 8'h40});
      while (!conv_done_irq_o) @(posedge sys_clk_i);
      `CHK(cyc - t0 >= 15 << d && cyc - t0 <= (16 << d) + 6, '1)
      xfer('0, 12'h000, '0, {26'h0, w0});
      xfer('0, 12'h00c, '0, {26'h0, hi});
      xfer('0, 12'h010, '0, {26'h0, lo});
    end
    xfer('1, 12'h000, 8'ha0, '0);
    xfer('1, 12'h000, 8'h20, '0);
    xfer('1, 12'h000, 8'ha0, '0);
    xfer('0, 12'h000, '0, {26'h0, 8'ha0});
    // Restart, then power off in mid-run: results must survive
    xfer('1, 12'h000, 8'h20, '0);
    xfer('0, 12'h000, '0, {26'h0, 8'h60});
    xfer('1, 12'h000, 8'h00, '0);
    `CHK(analog_o.pwr_en, 1'b0)
    xfer('1, 12'h000, 8'h80, '0);
    xfer('1, 12'h000, 8'h00, '0);
    xfer('0, 12'h000, '0, '0);
    repeat (200) @(posedge sys_clk_i);
    xfer('0, 12'h000, '0, '0);
    xfer('0, 12'h00c, '0, {26'h0, hi});
    xfer('0, 12'h010, '0, {26'h0, lo});
    results();
  end
endmodule
